/* verilog/mau_pkg.sv */
// Shared types and constants of the modulo address update block and its instruction feeder.
package mau_pkg;

   // Instruction kinds presented to the address core.
   typedef enum logic [3:0] {
      OP_NOP     = 4'h0,
      OP_WRITE   = 4'h1,
      OP_READ    = 4'h2,
      OP_ADDR    = 4'h3,
      OP_BF_SET  = 4'h4,
      OP_BF_CLR  = 4'h5,
      OP_BF_CHG  = 4'h6,
      OP_BF_TSTH = 4'h7,
      OP_BF_TSTL = 4'h8
   } mau_op_e;

   // Register selects; pointers and the stack pointer come first.
   typedef enum logic [2:0] {
      RG_FIRST    = 3'h0,
      RG_SECOND   = 3'h1,
      RG_THIRD    = 3'h2,
      RG_FOURTH   = 3'h3,
      RG_STACK    = 3'h4,
      RG_OFFSET   = 3'h5,
      RG_MODIFIER = 3'h6
   } mau_reg_e;

   // Addressing modes.
   typedef enum logic [2:0] {
      AM_NO_UPDATE    = 3'h0,
      AM_POST_INC     = 3'h1,
      AM_POST_DEC     = 3'h2,
      AM_POST_OFFSET  = 3'h3,
      AM_INDEX_OFFSET = 3'h4,
      AM_DISP         = 3'h5,
      AM_ABSOLUTE     = 3'h6
   } mau_mode_e;

   localparam int          NUM_REGS      = 7;
   localparam logic [15:0] PTR_RST       = 16'h0000;
   localparam logic [15:0] MOD_LINEAR    = 16'hFFFF;
   localparam int          MOD_SECOND_BIT = 15;
   localparam int          MOD_VAL_W     = 14;
   localparam logic [15:0] STEP_INC      = 16'h0001;
   localparam logic [15:0] STEP_DEC      = 16'hFFFF;

   localparam logic [NUM_REGS-1:0][15:0] REGS_RST =
      {MOD_LINEAR, PTR_RST, PTR_RST, PTR_RST, PTR_RST, PTR_RST, PTR_RST};

   // Feeder register map on APB, byte addresses.
   localparam logic [11:0] OFF_CMD    = 12'h000;
   localparam logic [11:0] OFF_DATA   = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_ADDR   = 12'h00C;
   localparam logic [11:0] OFF_RDATA  = 12'h010;
   localparam logic [11:0] OFF_STALLS = 12'h014;

   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_SEL_LSB  = 4;
   localparam int CMD_MODE_LSB = 8;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_TEST_BIT  = 1;

endpackage : mau_pkg

/* verilog/mau_ins_if.sv */
// Instruction link between the feeder and the modulo address core.
`timescale 1ns/1ps
interface mau_ins_if;
   logic               valid;
   logic               ready;
   logic               stall;
   mau_pkg::mau_op_e   op;
   mau_pkg::mau_reg_e  sel;
   mau_pkg::mau_mode_e mode;
   logic [15:0]        data;
   logic [15:0]        addr;
   logic               addr_valid;
   logic [15:0]        rdata;
   logic               rdata_valid;
   logic               test;

   modport core (
      input  valid,
      input  op,
      input  sel,
      input  mode,
      input  data,
      output ready,
      output stall,
      output addr,
      output addr_valid,
      output rdata,
      output rdata_valid,
      output test
   );

   modport feeder (
      output valid,
      output op,
      output sel,
      output mode,
      output data,
      input  ready,
      input  stall,
      input  addr,
      input  addr_valid,
      input  rdata,
      input  rdata_valid,
      input  test
   );
endinterface : mau_ins_if

/* verilog/mau_addr_core.sv */
// Modulo address update datapath with the offset write hazard stall.
//
// Notes on behaviour
// - Large offset multiple of block: linear jump.
// - Software loads that offset as positive value.
// - Pointer outside buffer still wraps by modulo.
// - Offset magnitude at most modifier plus one.
// - Lower bound is pointer with low bits cleared.
// - Linear math for third, fourth, absolute, no-update.
// - Offset write then offset use: one stall.
// - Stall also for stack and indexed offset.
// - Pointer, stack or modifier writes never stall.
// - Plain data reads create no extra cycle.
// - Displacement mode uses fresh value, no stall.
// - Bitfield writes to offset never stall.
// - Modifier is length minus one; top bit extends.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module mau_addr_core (
   input  logic        pclk,
   input  logic        presetn,
   mau_ins_if.core     ins,
   output logic [15:0] stack_ptr,
   output logic        modulo_on
);

   typedef struct packed {
      logic [mau_pkg::NUM_REGS-1:0][15:0] regs;
      logic                               pend_v;
      mau_pkg::mau_reg_e                  pend_reg;
      logic [15:0]                        pend_val;
      logic                               off_wr;
      logic [15:0]                        addr;
      logic                               addr_v;
      logic [15:0]                        rdata;
      logic                               rdata_v;
      logic                               test;
   } mau_core_s;

   localparam mau_core_s CORE_RST = '{regs:     mau_pkg::REGS_RST,
                                      pend_reg: mau_pkg::RG_FIRST,
                                      default:  '0};

   mau_core_s q;
   mau_core_s d;
   logic      uses_off;
   logic      hazard;
   logic      accept;

   // Single wrap detection: the offset is assumed to stay within one buffer length.
   function automatic logic [15:0] mau_mod_step(
      input logic [15:0] p,
      input logic [15:0] n,
      input logic [13:0] m
   );
      logic [15:0] mask;
      logic [15:0] lower;
      logic [17:0] sum;
      logic [17:0] upper;
      logic [17:0] span;
      logic [17:0] res;
      mask  = {2'h0, m};
      mask  = mask | (mask >> 1);
      mask  = mask | (mask >> 2);
      mask  = mask | (mask >> 4);
      mask  = mask | (mask >> 8);
      lower = p & ~mask;
      sum   = {2'h0, p} + {{2{n[15]}}, n};
      upper = {2'h0, lower} + {4'h0, m};
      span  = {4'h0, m} + 18'h00001;
      res   = sum;
      if (!n[15] && (n > {2'h0, m}) && ((n & mask) == 16'h0000)) begin
         res = sum;
      end else if ($signed(sum) > $signed(upper)) begin
         res = sum - span;
      end else if ($signed(sum) < $signed({2'h0, lower})) begin
         res = sum + span;
      end
      mau_mod_step = res[15:0];
   endfunction : mau_mod_step

   // The offset feeds the arithmetic in both post-update and indexed forms, for any base.
   assign uses_off = (ins.op == mau_pkg::OP_ADDR) &&
                     ((ins.mode == mau_pkg::AM_POST_OFFSET) ||
                      (ins.mode == mau_pkg::AM_INDEX_OFFSET));

   // The flag is only set by a plain offset write, so one refused cycle clears it.
   assign hazard = q.off_wr && uses_off;
   assign accept = ins.valid && !hazard;

   assign ins.ready       = !hazard;
   assign ins.stall       = ins.valid && hazard;
   assign ins.addr        = q.addr;
   assign ins.addr_valid  = q.addr_v;
   assign ins.rdata       = q.rdata;
   assign ins.rdata_valid = q.rdata_v;
   assign ins.test        = q.test;
   assign stack_ptr       = q.regs[mau_pkg::RG_STACK];
   assign modulo_on       = (q.regs[mau_pkg::RG_MODIFIER] != mau_pkg::MOD_LINEAR);

   always_comb begin
      logic [15:0] fwd;
      logic [15:0] base;
      logic [15:0] step;
      logic [15:0] newp;
      logic [15:0] modv;
      logic        modsel;
      logic        is_ptr;
      fwd    = 16'h0000;
      base   = 16'h0000;
      step   = 16'h0000;
      newp   = 16'h0000;
      modv   = q.regs[mau_pkg::RG_MODIFIER];
      modsel = 1'b0;
      is_ptr = (ins.sel <= mau_pkg::RG_STACK);

      d         = q;
      d.addr_v  = 1'b0;
      d.rdata_v = 1'b0;
      d.pend_v  = 1'b0;
      d.off_wr  = 1'b0;

      // A register write lands one cycle late; an address calculation in the next cycle sees the old value,
      // except a displacement base (forwarded) or an offset use after a plain offset write (stalled); the rest is left to software.
      if (q.pend_v) begin
         d.regs[q.pend_reg] = q.pend_val;
      end

      if (q.pend_v && (q.pend_reg == ins.sel)) begin
         fwd = q.pend_val;
      end else begin
         fwd = q.regs[ins.sel];
      end

      // Only the first pointer, or the second with the top modifier bit, wraps.
      modsel = (modv != mau_pkg::MOD_LINEAR) &&
               ((ins.sel == mau_pkg::RG_FIRST) ||
                ((ins.sel == mau_pkg::RG_SECOND) && modv[mau_pkg::MOD_SECOND_BIT]));

      if (ins.mode == mau_pkg::AM_DISP) begin
         base = fwd;
      end else begin
         base = q.regs[ins.sel];
      end

      unique case (ins.mode)
         mau_pkg::AM_POST_INC: begin
            step = mau_pkg::STEP_INC;
         end
         mau_pkg::AM_POST_DEC: begin
            step = mau_pkg::STEP_DEC;
         end
         mau_pkg::AM_POST_OFFSET,
         mau_pkg::AM_INDEX_OFFSET: begin
            step = q.regs[mau_pkg::RG_OFFSET];
         end
         mau_pkg::AM_DISP: begin
            step = ins.data;
         end
         default: begin
            step = 16'h0000;
         end
      endcase

      if (modsel) begin
         newp = mau_mod_step(base, step, modv[mau_pkg::MOD_VAL_W-1:0]);
      end else begin
         newp = base + step;
      end

      if (accept) begin
         unique case (ins.op)
            mau_pkg::OP_NOP: begin
            end
            mau_pkg::OP_WRITE: begin
               d.pend_v   = 1'b1;
               d.pend_reg = ins.sel;
               d.pend_val = ins.data;
               d.off_wr   = (ins.sel == mau_pkg::RG_OFFSET);
            end
            mau_pkg::OP_READ: begin
               d.rdata   = fwd;
               d.rdata_v = 1'b1;
            end
            mau_pkg::OP_BF_SET: begin
               d.pend_v   = 1'b1;
               d.pend_reg = ins.sel;
               d.pend_val = fwd | ins.data;
            end
            mau_pkg::OP_BF_CLR: begin
               d.pend_v   = 1'b1;
               d.pend_reg = ins.sel;
               d.pend_val = fwd & ~ins.data;
            end
            mau_pkg::OP_BF_CHG: begin
               d.pend_v   = 1'b1;
               d.pend_reg = ins.sel;
               d.pend_val = fwd ^ ins.data;
            end
            mau_pkg::OP_BF_TSTH: begin
               d.test = ((fwd & ins.data) == ins.data);
            end
            mau_pkg::OP_BF_TSTL: begin
               d.test = ((fwd & ins.data) == 16'h0000);
            end
            mau_pkg::OP_ADDR: begin
               d.addr_v = 1'b1;
               unique case (ins.mode)
                  mau_pkg::AM_NO_UPDATE: begin
                     d.addr = base;
                  end
                  mau_pkg::AM_POST_INC,
                  mau_pkg::AM_POST_DEC,
                  mau_pkg::AM_POST_OFFSET: begin
                     d.addr = base;
                     if (is_ptr) begin
                        d.regs[ins.sel] = newp;
                     end
                  end
                  mau_pkg::AM_INDEX_OFFSET,
                  mau_pkg::AM_DISP: begin
                     d.addr = newp;
                  end
                  mau_pkg::AM_ABSOLUTE: begin
                     d.addr = ins.data;
                  end
                  default: begin
                     d.addr_v = 1'b0;
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

endmodule : mau_addr_core

/* verilog/mau_feeder.sv */
// Instruction feeder that takes orders from software over APB and issues them to the core.
`timescale 1ns/1ps
module mau_feeder (
   input  logic        pclk,
   input  logic        presetn,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [11:0] paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   mau_ins_if.feeder   ins
);

   typedef struct packed {
      logic [3:0]  op;
      logic [2:0]  sel;
      logic [2:0]  mode;
      logic [15:0] data;
      logic        busy;
      logic [15:0] addr;
      logic [15:0] rdata;
      logic [15:0] stalls;
      logic [31:0] prdata;
   } mau_feed_s;

   mau_feed_s q;
   mau_feed_s d;
   logic      mapped;
   logic      access;

   assign access = psel && penable;
   assign mapped = (paddr == mau_pkg::OFF_CMD)    || (paddr == mau_pkg::OFF_DATA)  ||
                   (paddr == mau_pkg::OFF_STATUS) || (paddr == mau_pkg::OFF_ADDR)  ||
                   (paddr == mau_pkg::OFF_RDATA)  || (paddr == mau_pkg::OFF_STALLS);

   // A new command waits while the previous one is still held by a stall.
   assign pready  = !(pwrite && (paddr == mau_pkg::OFF_CMD) && q.busy);
   assign pslverr = access && !mapped;
   assign prdata  = q.prdata;

   assign ins.valid = q.busy;
   assign ins.op    = mau_pkg::mau_op_e'(q.op);
   assign ins.sel   = mau_pkg::mau_reg_e'(q.sel);
   assign ins.mode  = mau_pkg::mau_mode_e'(q.mode);
   assign ins.data  = q.data;

   always_comb begin
      d = q;
      if (q.busy && ins.ready) begin
         d.busy = 1'b0;
      end
      if (ins.addr_valid) begin
         d.addr = ins.addr;
      end
      if (ins.rdata_valid) begin
         d.rdata = ins.rdata;
      end
      if (access && pready && pwrite && mapped) begin
         unique case (paddr)
            mau_pkg::OFF_CMD: begin
               d.op   = pwdata[mau_pkg::CMD_OP_LSB +: 4];
               d.sel  = pwdata[mau_pkg::CMD_SEL_LSB +: 3];
               d.mode = pwdata[mau_pkg::CMD_MODE_LSB +: 3];
               d.busy = 1'b1;
            end
            mau_pkg::OFF_DATA: begin
               d.data = pwdata[15:0];
            end
            mau_pkg::OFF_STALLS: begin
               d.stalls = 16'h0000;
            end
            default: begin
            end
         endcase
      end
      // Counting after the clear lets a stall in the clearing cycle survive.
      if (ins.stall) begin
         d.stalls = d.stalls + 16'h0001;
      end
      if (psel && !penable) begin
         unique case (paddr)
            mau_pkg::OFF_CMD: begin
               d.prdata = {21'h000000, q.mode, 1'b0, q.sel, q.op};
            end
            mau_pkg::OFF_DATA: begin
               d.prdata = {16'h0000, q.data};
            end
            mau_pkg::OFF_STATUS: begin
               d.prdata = 32'h00000000;
               d.prdata[mau_pkg::ST_BUSY_BIT] = q.busy;
               d.prdata[mau_pkg::ST_TEST_BIT] = ins.test;
            end
            mau_pkg::OFF_ADDR: begin
               d.prdata = {16'h0000, q.addr};
            end
            mau_pkg::OFF_RDATA: begin
               d.prdata = {16'h0000, q.rdata};
            end
            mau_pkg::OFF_STALLS: begin
               d.prdata = {16'h0000, q.stalls};
            end
            default: begin
               d.prdata = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : mau_feeder

/* testbench/mau_ins_monitor.sv */
// Concurrent checks on the instruction link between the feeder and the address core.
`timescale 1ns/1ps
module mau_ins_monitor (
   input logic               pclk,
   input logic               presetn,
   input logic               valid,
   input logic               ready,
   input logic               stall,
   input mau_pkg::mau_op_e   op,
   input mau_pkg::mau_reg_e  sel,
   input mau_pkg::mau_mode_e mode,
   input logic               addr_valid,
   input logic               rdata_valid
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic take;
   logic offw;
   logic offuse;
   assign take = valid && ready;
   assign offw = take && op == mau_pkg::OP_WRITE && sel == mau_pkg::RG_OFFSET;
   assign offuse = valid && op == mau_pkg::OP_ADDR &&
      (mode == mau_pkg::AM_POST_OFFSET || mode == mau_pkg::AM_INDEX_OFFSET);
   chk_stall_not_ready: assert property (stall == (valid && !ready))
      else $error("stall differs from valid without ready");
   chk_offset_use_stall: assert property (offw ##1 offuse |-> stall)
      else $error("offset use after offset write did not stall");
   chk_stall_single_cycle: assert property (stall |=> take)
      else $error("stall lasted more than one cycle");
   chk_no_other_stall: assert property (!offw |=> !stall)
      else $error("stall without a preceding offset write");
   chk_disp_no_stall: assert property (
      valid && op == mau_pkg::OP_ADDR && mode == mau_pkg::AM_DISP |-> !stall)
      else $error("displacement mode stalled");
   chk_idle_ready: assert property (!valid |-> ready)
      else $error("ready low while idle");
   chk_addr_answer: assert property (
      take && op == mau_pkg::OP_ADDR |=> addr_valid && !rdata_valid)
      else $error("address result missing one cycle after issue");
   chk_read_no_addr: assert property (
      take && op == mau_pkg::OP_READ |=> rdata_valid && !addr_valid)
      else $error("read result missing one cycle after issue");
   cover property (take && op == mau_pkg::OP_ADDR);
   cover property (take && op == mau_pkg::OP_READ);
   cover property (take && op == mau_pkg::OP_WRITE);
endmodule : mau_ins_monitor

/* testbench/modulo_address_update_hazards_tb.sv */
// Bench: feeder and core joined over the link, plus a directly driven core for hazards.
`timescale 1ns/1ps
module modulo_address_update_hazards_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] sp_d;
   logic        mod_d;
   logic [31:0] rd;
   logic        er;
   logic [15:0] got_q[$];
   logic [15:0] exp_q[$];
   int          err_total;
   int          checks_done;
   int          st;
   mau_ins_if ins_if();
   mau_ins_if drv_if();
   mau_feeder mau_feeder_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ins(ins_if));
   mau_addr_core mau_addr_core_i (.pclk(pclk), .presetn(presetn), .ins(ins_if),
      .stack_ptr(), .modulo_on());
   // A second core lets the bench issue instructions back to back, which the feeder never does.
   mau_addr_core mau_addr_core_i2 (.pclk(pclk), .presetn(presetn), .ins(drv_if),
      .stack_ptr(sp_d), .modulo_on(mod_d));
   mau_ins_monitor mau_ins_monitor_i (.pclk(pclk), .presetn(presetn), .valid(ins_if.valid),
      .ready(ins_if.ready), .stall(ins_if.stall), .op(ins_if.op), .sel(ins_if.sel),
      .mode(ins_if.mode), .addr_valid(ins_if.addr_valid), .rdata_valid(ins_if.rdata_valid));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (drv_if.addr_valid === 1'b1) got_q.push_back(drv_if.addr);
      if (drv_if.rdata_valid === 1'b1) got_q.push_back(drv_if.rdata);
   end
   function automatic logic [15:0] smear(input logic [15:0] m);
      for (int i = 0; i < 4; i++) m = m | (m >> (1 << i));
      return m;
   endfunction : smear
   function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] n,
      input logic [15:0] md, input logic on);
      logic [15:0] m;
      logic [15:0] k;
      logic [15:0] s;
      m = {2'b00, md[13:0]};
      k = smear(m);
      s = p + n;
      if (!on || (!n[15] && n > m && (n & k) == 16'h0000)) return s;
      if (s > (p & ~k) + m) return s - m - 16'h0001;
      if (s < (p & ~k)) return s + m + 16'h0001;
      return s;
   endfunction : nxt
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n > 50) begin
            err_total++;
            give_verdict();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Command word layout: op in bits 3:0, register in 6:4, mode in 10:8.
   task automatic put(input logic [10:0] c, input logic [15:0] d);
      drv_if.valid <= 1'b1;
      drv_if.op <= mau_pkg::mau_op_e'(c[3:0]);
      drv_if.sel <= mau_pkg::mau_reg_e'(c[6:4]);
      drv_if.mode <= mau_pkg::mau_mode_e'(c[10:8]);
      drv_if.data <= d;
      st = 0;
      @(posedge pclk);
      while (drv_if.ready !== 1'b1) begin
         st++;
         if (st > 4) begin
            err_total++;
            give_verdict();
         end
         @(posedge pclk);
      end
   endtask : put
   task automatic idle(input int n);
      drv_if.valid <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask : idle
   task automatic drain();
      idle(3);
      check("result count", 32'(got_q.size()), 32'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0)
         check("result", got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask : drain
   task automatic pair(input logic [10:0] a, input logic [15:0] ad, input logic [10:0] b,
      input logic [15:0] bd, input int stl, input logic [15:0] res);
      put(a, ad);
      put(b, bd);
      check("stall cycles", 32'(st), 32'(stl));
      exp_q.push_back(res);
      drain();
   endtask : pair
   initial begin
      logic [15:0] md;
      logic [15:0] p;
      logic [15:0] n;
      logic [15:0] k;
      logic [15:0] q;
      int          s;
      int          m;
      int          mm;
      err_total = 0;
      checks_done = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      drv_if.valid = 1'b0;
      drv_if.op = mau_pkg::OP_NOP;
      drv_if.sel = mau_pkg::RG_FIRST;
      drv_if.mode = mau_pkg::AM_NO_UPDATE;
      drv_if.data = 16'h0000;
      void'($urandom(32'h0322));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, 12'h004, 32'h0000ABCD);
      apb(1'b1, 12'h000, 32'h00000603);
      apb(1'b1, 12'h000, 32'h00000001);
      apb(1'b1, 12'h000, 32'h00000002);
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h00C, 32'h00000000);
      check("absolute address", rd, 32'h0000ABCD);
      apb(1'b0, 12'h010, 32'h00000000);
      check("pointer read", rd, 32'h0000ABCD);
      apb(1'b0, 12'h014, 32'h00000000);
      check("stall count", rd, 32'h00000000);
      apb(1'b0, 12'h018, 32'h00000000);
      check("unmapped error", {31'h0, er}, 32'h00000001);
      pair(11'h051, 16'h0003, 11'h343, 16'h0000, 1, 16'h0000);
      check("stack pointer", sp_d, 16'h0003);
      pair(11'h051, 16'h0005, 11'h423, 16'h0000, 1, 16'h0005);
      pair(11'h054, 16'h0002, 11'h323, 16'h0000, 0, 16'h0000);
      pair(11'h057, 16'h0007, 11'h423, 16'h0000, 0, 16'h000C);
      check("bit test", drv_if.test, 1'b1);
      pair(11'h001, 16'h0040, 11'h103, 16'h0000, 0, 16'h0000);
      pair(11'h061, 16'h0004, 11'h023, 16'h0000, 0, 16'h0005);
      check("modulo on", mod_d, 1'b1);
      pair(11'h021, 16'h1234, 11'h022, 16'h0000, 0, 16'h1234);
      pair(11'h021, 16'h0200, 11'h523, 16'h0011, 0, 16'h0211);
      pair(11'h051, 16'h0001, 11'h052, 16'h0000, 0, 16'h0001);
      for (int i = 0; i < 70; i++) begin
         m = i % 7;
         s = i % 5;
         mm = 1 + int'($urandom % 60);
         md = 16'(mm) | ((i % 2) ? 16'h8000 : 16'h0000);
         k = smear(16'(mm));
         p = 16'(($urandom % 200) + 1) * 16'h0100 + (16'($urandom) & k);
         if (i % 3 == 0) n = (k + 16'h0001) * 16'(1 + $urandom % 3);
         else n = 16'(int'($urandom % (2 * mm + 3)) - mm - 1);
         q = nxt(p, (m == 1) ? 16'h0001 : (m == 2) ? 16'hFFFF : n, md,
            s == 0 || (s == 1 && md[15]));
         put(11'h061, md);
         put(11'h051, n);
         put(11'(s * 16 + 1), p);
         idle(2);
         put(11'(m * 256 + s * 16 + 3), n);
         idle(2);
         put(11'(s * 16 + 2), 16'h0000);
         exp_q.push_back((m == 6) ? n : (m == 4 || m == 5) ? q : p);
         exp_q.push_back((m >= 1 && m <= 3) ? q : p);
         drain();
      end
      give_verdict();
   end
endmodule : modulo_address_update_hazards_tb
